//--- hw/epsq_pkg.sv
// constants for the eprom program/verify sequencer (host side)
// assumes a 125 MHz system clock; all times converted to cycles here
package epsq_pkg;
  localparam int CLK_MHZ = 125;
  // program pulse: nominal 100 us, bounds 95..105 us
  localparam int PULSE_NOM_US = 100;
  localparam int PULSE_CYC = PULSE_NOM_US * CLK_MHZ;
  // setup times (address, data, supplies, output enable), 2 us each
  localparam int SETUP_US = 2;
  localparam int SETUP_CYC = SETUP_US * CLK_MHZ;
  // data valid after output enable falls, 150 ns, rounded up
  localparam int OE_VALID_NS = 150;
  localparam int OE_VALID_CYC = (OE_VALID_NS * CLK_MHZ + 999) / 1000;
  // output float after output enable rises, 130 ns, rounded up
  localparam int FLOAT_NS = 130;
  localparam int FLOAT_CYC = (FLOAT_NS * CLK_MHZ + 999) / 1000;
  // retry pulses allowed per byte in the verify pass
  localparam int MAX_RETRY = 10;
  localparam int ADDR_W = 15;
  localparam int TMR_W = 16;
  // identification readout address: byte select is bit 0
  localparam logic [ADDR_W-1:0] ID_ADDR_MFG = 15'h0000;
  localparam logic [ADDR_W-1:0] ID_ADDR_DEV = 15'h0001;
  typedef enum logic [3:0] {
    EPSQ_IDLE = 4'h0,
    EPSQ_PWR = 4'h1,
    EPSQ_PGM1 = 4'h3,
    EPSQ_VFY = 4'h2,
    EPSQ_RETRY = 4'hA,
    EPSQ_RAMP = 4'h6,
    EPSQ_READ = 4'h7,
    EPSQ_IDRD = 4'h4,
    EPSQ_DONE = 4'h5
  } epsq_state_e;
endpackage

//--- hw/epsq_timer.sv
// load-and-count-down timer used for every timed phase
// assumes the caller loads it with a cycle count and waits for done
`timescale 1ns/1ns
`default_nettype none
module epsq_timer
  import epsq_pkg::*;
#(
  parameter int W = TMR_W
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic load,
  input wire logic [W-1:0] count,
  output logic done
);
  logic [W-1:0] cnt_r;
  // counts down to zero, holds there; load wins over counting
  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_r <= '0;
    end else if (load) begin
      cnt_r <= count;
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - 1'b1;
    end
  end
  // done depends on the count alone; the caller builds load from done
  assign done = (cnt_r == '0);
endmodule
`default_nettype wire

//--- hw/epsq_host.sv
// host programmer for a 32K x 8 uv eprom: program, verify, read back, id read
// assumes external supply switches follow vcc_prog_en / vpp_prog_en and the
// user holds source data valid for src_addr one cycle after it changes
//
// How it works
// - chip enable is held low 100 us plus one clock for every program pulse.
// - start at address zero and raise both supplies before pulsing.
// - first pass gives each byte one pulse, no verify reads.
// - second pass verifies each byte, retrying with a verify after each pulse.
// - a byte still failing after ten retry pulses fails the device.
// - a verified byte advances the address until all are checked.
// - supplies return to normal, then, if verify passed, each byte is read and compared.
// - core supply up no later, and down no earlier, than program supply.
// - verify reads wait data-valid delay and output-float delay.
// - id mode drives both strobes low, high-voltage pin up, other address low.
`timescale 1ns/1ns
`default_nettype none
module epsq_host
  import epsq_pkg::*;
#(
  parameter int DEPTH = 32768
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic start,
  input wire logic id_start,
  input wire logic [7:0] src_data,
  output logic [ADDR_W-1:0] src_addr,
  output logic busy,
  output logic pass,
  output logic fail,
  output logic [7:0] id_mfg,
  output logic [7:0] id_dev,
  output logic [ADDR_W-1:0] addr,
  output logic ce_n,
  output logic oe_n,
  output logic [7:0] data_out,
  output logic data_oe,
  input wire logic [7:0] data_outputs,
  output logic vcc_prog_en,
  output logic vpp_prog_en,
  output logic id_mode_high_voltage_pin
);
  localparam logic [ADDR_W-1:0] LAST = ADDR_W'(DEPTH - 1);

  epsq_state_e state_r;
  logic [2:0] step_r;
  logic [3:0] retry_r;
  logic [7:0] dq_s1_r, dq_s2_r;
  logic tmr_load;
  logic [TMR_W-1:0] tmr_count;
  logic tmr_done;

  ////////////////////////////////////////////////////////////////////////
  // pin inputs pass two flops before anyone compares them
  always_ff @(posedge clk) begin
    if (srst) begin
      dq_s1_r <= 8'h00;
      dq_s2_r <= 8'h00;
    end else begin
      dq_s1_r <= data_outputs;
      dq_s2_r <= dq_s1_r;
    end
  end

  epsq_timer #(.W(TMR_W)) u_tmr (
    .clk(clk),
    .srst(srst),
    .load(tmr_load),
    .count(tmr_count),
    .done(tmr_done)
  );

  ////////////////////////////////////////////////////////////////////////
  // per-step timer loads; a step ends when the timer drains.
  // steps: 0 setup, 1 strobe active, 2 sample, 3 release / float
  always_comb begin
    tmr_load = 1'b0;
    tmr_count = '0;
    if (tmr_done && state_r != EPSQ_IDLE && state_r != EPSQ_DONE) begin
      tmr_load = 1'b1;
      case (step_r)
        3'd0: begin
          if (state_r == EPSQ_PGM1 || state_r == EPSQ_RETRY) begin
            tmr_count = TMR_W'(PULSE_CYC);
          end else begin
            // data valid wait, plus the input synchroniser
            tmr_count = TMR_W'(OE_VALID_CYC + 2);
          end
        end
        3'd1: tmr_count = TMR_W'(1);
        // float delay before data is driven again
        3'd2: tmr_count = TMR_W'(FLOAT_CYC);
        default: tmr_count = TMR_W'(SETUP_CYC);
      endcase
    end
  end

  logic match;
  assign match = (dq_s2_r == src_data);

  ////////////////////////////////////////////////////////////////////////
  // main sequencer: state, step, address, retry counter
  always_ff @(posedge clk) begin
    if (srst) begin
      state_r <= EPSQ_IDLE;
      step_r <= 3'd0;
      retry_r <= 4'h0;
      addr <= '0;
      pass <= 1'b0;
      fail <= 1'b0;
      id_mfg <= 8'h00;
      id_dev <= 8'h00;
    end else begin
      case (state_r)
        EPSQ_IDLE: begin
          step_r <= 3'd3;
          retry_r <= 4'h0;
          if (start) begin
            // first location selected before supplies rise
            addr <= '0;
            pass <= 1'b0;
            fail <= 1'b0;
            state_r <= EPSQ_PWR;
          end else if (id_start) begin
            // id reads begin at byte select 0
            addr <= ID_ADDR_MFG;
            state_r <= EPSQ_IDRD;
          end
        end
        EPSQ_PWR: begin
          // two setup periods: core first, then program supply
          if (tmr_load) begin
            step_r <= step_r + 3'd1;
            if (step_r == 3'd4) begin
              step_r <= 3'd0;
              state_r <= EPSQ_PGM1;
            end
          end
        end
        default: begin
          if (tmr_load) begin
            step_r <= (step_r == 3'd3) ? 3'd0 : step_r + 3'd1;
            if (step_r == 3'd2) begin
              case (state_r)
                EPSQ_PGM1: begin
                  // one pulse per byte, no verify in this pass
                  if (addr == LAST) begin
                    addr <= '0;
                    state_r <= EPSQ_VFY;
                  end else begin
                    addr <= addr + 1'b1;
                  end
                end
                EPSQ_VFY, EPSQ_RETRY: begin
                  if (state_r == EPSQ_RETRY) begin
                    // verify read follows every retry pulse
                    state_r <= EPSQ_VFY;
                  end else if (match) begin
                    retry_r <= 4'h0;
                    if (addr == LAST) begin
                      addr <= '0;
                      state_r <= EPSQ_RAMP;
                    end else begin
                      addr <= addr + 1'b1;
                    end
                  end else if (retry_r == 4'(MAX_RETRY)) begin
                    fail <= 1'b1;
                    state_r <= EPSQ_RAMP;
                  end else begin
                    retry_r <= retry_r + 4'h1;
                    state_r <= EPSQ_RETRY;
                  end
                end
                EPSQ_RAMP: begin
                  // supplies lowered, now read every byte back unless verify failed
                  addr <= '0;
                  state_r <= fail ? EPSQ_DONE : EPSQ_READ;
                end
                EPSQ_READ: begin
                  // final compare decides pass or fail
                  if (!match) begin
                    fail <= 1'b1;
                    state_r <= EPSQ_DONE;
                  end else if (addr == LAST) begin
                    pass <= 1'b1;
                    state_r <= EPSQ_DONE;
                  end else begin
                    addr <= addr + 1'b1;
                  end
                end
                EPSQ_IDRD: begin
                  // byte select picks maker then device code
                  if (addr[0] == 1'b0) begin
                    id_mfg <= dq_s2_r;
                    addr <= ID_ADDR_DEV;
                  end else begin
                    id_dev <= dq_s2_r;
                    addr <= '0;
                    state_r <= EPSQ_DONE;
                  end
                end
                default: state_r <= EPSQ_IDLE;
              endcase
            end
          end
        end
        EPSQ_DONE: state_r <= EPSQ_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // strobes and data drive, registered from state and step
  logic pgm_ph, rd_ph;
  assign pgm_ph = (state_r == EPSQ_PGM1 || state_r == EPSQ_RETRY);
  assign rd_ph = (state_r == EPSQ_VFY || state_r == EPSQ_READ || state_r == EPSQ_IDRD);
  always_ff @(posedge clk) begin
    if (srst) begin
      ce_n <= 1'b1;
      oe_n <= 1'b1;
      data_oe <= 1'b0;
      data_out <= 8'h00;
    end else begin
      // chip enable low during the pulse step, and during read steps 1 and 2
      ce_n <= !((pgm_ph && step_r == 3'd1) || (rd_ph && (step_r == 3'd1 || step_r == 3'd2)));
      // both strobes released together ends device drive
      oe_n <= !(rd_ph && (step_r == 3'd1 || step_r == 3'd2));
      // no drive while output enable low or float pending
      data_oe <= pgm_ph && step_r != 3'd3;
      data_out <= src_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // supplies: core leads on the way up and trails on the way down
  always_ff @(posedge clk) begin
    if (srst) begin
      vcc_prog_en <= 1'b0;
      vpp_prog_en <= 1'b0;
    end else begin
      // vcc raised a setup period before vpp
      if (state_r == EPSQ_PWR) begin
        vcc_prog_en <= 1'b1;
        // vpp rises only as the first setup period ends, a full setup after vcc
        vpp_prog_en <= (step_r == 3'd4) && tmr_load;
      end else if (state_r == EPSQ_RAMP) begin
        // vpp dropped first, vcc two steps later
        vpp_prog_en <= 1'b0;
        vcc_prog_en <= (step_r == 3'd0 || step_r == 3'd3);
      end else if (state_r == EPSQ_READ || state_r == EPSQ_DONE || state_r == EPSQ_IDLE) begin
        vpp_prog_en <= 1'b0;
        vcc_prog_en <= vcc_prog_en && vpp_prog_en;
      end
    end
  end

  // high-voltage pin only during identification reads
  always_ff @(posedge clk) begin
    if (srst) begin
      id_mode_high_voltage_pin <= 1'b0;
    end else begin
      id_mode_high_voltage_pin <= (state_r == EPSQ_IDRD);
    end
  end

  assign busy = (state_r != EPSQ_IDLE);
  assign src_addr = addr;
endmodule
`default_nettype wire

//--- tb/epsq_props.sv
// pin-level checker for the host sequencer
// assumes it is bound onto epsq_host and runs on its single clock
`timescale 1ns/1ns
`default_nettype none
module epsq_props
  import epsq_pkg::*;
#(
  parameter int DEPTH = 32768
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic pass,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic data_oe,
  input wire logic vcc_prog_en,
  input wire logic vpp_prog_en,
  input wire logic id_mode_high_voltage_pin
);
  localparam int PW_MIN = 11875;
  localparam int PW_MAX = 13125;
  int ce_lo;
  int oe_lo;
  int oe_hi;
  int pcnt;
  //////////////////////////////
  // strobe timers; oe_hi saturates so long idle spells cannot wrap
  always_ff @(posedge clk) ce_lo <= (srst || ce_n) ? 0 : ce_lo + 1;
  always_ff @(posedge clk) oe_lo <= (srst || oe_n) ? 0 : oe_lo + 1;
  always_ff @(posedge clk) oe_hi <= srst ? 255 : (!oe_n ? 0 : (oe_hi < 255 ? oe_hi + 1 : 255));
  // program pulses on the current byte, cleared when the address moves
  always_ff @(posedge clk)
    pcnt <= (srst || $changed(addr)) ? 0 : pcnt + int'($rose(ce_n) && $past(oe_n));
  //////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  AST_PULSE_WIDTH:
    assert property ($rose(ce_n) && $past(oe_n) |-> ce_lo >= PW_MIN && ce_lo <= PW_MAX)
      else $error("program pulse width out of range");
  AST_PULSE_SUPPLY:
    assert property ($fell(ce_n) && data_oe |-> vcc_prog_en && vpp_prog_en)
      else $error("program pulse without raised supplies");
  AST_VPP_UNDER_VCC:
    assert property (vpp_prog_en |-> vcc_prog_en)
      else $error("program supply up without core supply");
  AST_READ_NO_DRIVE:
    assert property (!oe_n |-> !data_oe) else $error("host drives data while outputs enabled");
  AST_FLOAT_GAP:
    assert property ($rose(data_oe) |-> oe_hi >= FLOAT_CYC)
      else $error("host drove data before float delay");
  AST_VALID_WAIT:
    assert property ($rose(oe_n) |-> oe_lo >= OE_VALID_CYC)
      else $error("read strobe shorter than data valid delay");
  AST_RETRY_LIMIT:
    assert property (pcnt <= MAX_RETRY + 1) else $error("too many pulses on one byte");
  AST_ID_PINS:
    assert property (id_mode_high_voltage_pin && !oe_n |-> !ce_n && addr[ADDR_W-1:1] == 14'h0000)
      else $error("bad id mode pins");
  cover property ($rose(ce_n) && $past(oe_n));
  cover property (pcnt == 2);
  cover property (id_mode_high_voltage_pin && !oe_n);
  cover property ($rose(pass));
endmodule
bind epsq_host epsq_props #(.DEPTH(DEPTH)) u_props (.clk(clk), .srst(srst), .pass(pass),
  .addr(addr), .ce_n(ce_n), .oe_n(oe_n), .data_oe(data_oe), .vcc_prog_en(vcc_prog_en),
  .vpp_prog_en(vpp_prog_en), .id_mode_high_voltage_pin(id_mode_high_voltage_pin));
`default_nettype wire

//--- tb/epsq_dev_model.sv
// behavioural eprom seen from its pins, erased on srst
// assumes the bench resolves the shared data wire and sets need
`timescale 1ns/1ns
`default_nettype none
module epsq_dev_model
  import epsq_pkg::*;
#(
  parameter int DEPTH = 2,
  parameter logic [7:0] MFG_CODE = 8'hA5, // arbitrary value
  parameter logic [7:0] DEV_CODE = 8'h3B // arbitrary value
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic [7:0] din,
  input wire logic vpp,
  input wire logic id_pin,
  input wire logic [3:0] need,
  output logic [7:0] dq,
  output int pulses
);
  logic [7:0] mem [DEPTH];
  int cnt [DEPTH];
  int a;
  int ol;
  logic ce_d;
  logic pg;
  logic [7:0] last;
  logic drv;
  assign a = int'(addr) % DEPTH;
  assign drv = !ce_n && !oe_n && ol >= OE_VALID_CYC;
  // a byte keeps its zeros only after need pulses, so retries are forced
  always_ff @(posedge clk) begin
    ce_d <= ce_n;
    pg <= ce_n ? 1'b1 : (pg & oe_n);
    ol <= (ce_n || oe_n) ? 0 : ol + 1;
    // a released bus shows the inverse of the last driven byte, not a toggle
    last <= srst ? 8'h00 : (drv ? dq : last);
    if (srst) begin
      pulses <= 0;
      foreach (mem[i]) mem[i] <= 8'hFF;
      foreach (cnt[i]) cnt[i] <= 0;
    end else if (ce_n && !ce_d && pg && vpp) begin
      pulses <= pulses + 1;
      cnt[a] <= cnt[a] + 1;
      if (cnt[a] + 1 >= int'(need)) mem[a] <= mem[a] & din;
    end
  end
  // drives only with both strobes low
  // id byte picked by byte select
  always_comb begin
    if (drv) dq = id_pin ? (addr[0] ? DEV_CODE : MFG_CODE) : mem[a];
    else dq = ~last;
  end
endmodule
`default_nettype wire

//--- tb/tb.sv
// self-checking bench: host sequencer against the pin-level eprom model
// assumes DEPTH shortened to 2 so the runs fit in the cycle budget
`timescale 1ns/1ns
`default_nettype none
module tb
  import epsq_pkg::*;
;
  localparam logic [7:0] MFG = 8'hA5; // arbitrary value
  localparam logic [7:0] DEV = 8'h3B; // arbitrary value
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic start = 1'b0;
  logic id_start = 1'b0;
  logic [7:0] src_data = 8'h00;
  logic [3:0] need = 4'h1;
  logic [7:0] pat [2] = '{8'h00, 8'h00};
  logic [ADDR_W-1:0] src_addr, addr;
  logic busy, pass, fail, ce_n, oe_n, data_oe, vcc_en, vpp_en, hv;
  logic [7:0] id_mfg, id_dev, data_out, dq, bus;
  int pulses;
  int error_cnt = 0;
  int tests_run = 0;
  int cyc = 0;
  //////////////////////////////
  // shared data wire: host wins only while its enable is up
  assign bus = data_oe ? data_out : dq;
  epsq_host #(.DEPTH(2)) dut (.clk(clk), .srst(srst), .start(start), .id_start(id_start),
    .src_data(src_data), .src_addr(src_addr), .busy(busy), .pass(pass), .fail(fail),
    .id_mfg(id_mfg), .id_dev(id_dev), .addr(addr), .ce_n(ce_n), .oe_n(oe_n),
    .data_out(data_out), .data_oe(data_oe), .data_outputs(bus), .vcc_prog_en(vcc_en),
    .vpp_prog_en(vpp_en), .id_mode_high_voltage_pin(hv));
  epsq_dev_model #(.DEPTH(2), .MFG_CODE(MFG), .DEV_CODE(DEV)) dev (.clk(clk), .srst(srst),
    .addr(addr), .ce_n(ce_n), .oe_n(oe_n), .din(bus), .vpp(vpp_en), .id_pin(hv),
    .need(need), .dq(dq), .pulses(pulses));
  // clock, source data lookup and hang guard
  always #4 clk = ~clk;
  always @(posedge clk) src_data <= pat[src_addr[0]];
  always @(posedge clk) begin
    cyc <= cyc + 1;
    // all scenarios take about 82k cycles; the ceiling leaves some margin
    if (cyc == 95000) begin
      error_cnt++;
      $display("mismatch at %0t: run did not finish", $time);
      stop_test();
    end
  end
  //////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic do_reset();
    @(posedge clk);
    srst <= 1'b1;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
  endtask
  // one request, a refused id request while busy after a program request, then a bounded wait
  task automatic run(input logic go_id);
    int n;
    @(posedge clk);
    if (go_id) id_start <= 1'b1;
    else start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    id_start <= !go_id;
    @(posedge clk);
    id_start <= 1'b0;
    for (n = 0; n < 90000 && busy !== 1'b0; n++) @(negedge clk);
  endtask
  task automatic t_prog(input logic [3:0] nd, input logic [7:0] p0, input logic [7:0] p1,
    input int np);
    need <= nd;
    pat[0] <= p0;
    pat[1] <= p1;
    run(1'b0);
    chk(pass, 1'b1);
    chk(fail, 1'b0);
    chk(16'(pulses), 16'(np));
    chk(dev.mem[0], p0);
    chk(dev.mem[1], p1);
    chk(id_mfg, 8'h00);
    chk(vpp_en, 1'b0);
    chk(vcc_en, 1'b0);
    chk(data_oe, 1'b0);
    $display("test prog need %0d done", nd);
  endtask
  task automatic t_id();
    run(1'b1);
    chk(id_mfg, MFG);
    chk(id_dev, DEV);
    chk(hv, 1'b0);
    $display("test id read done");
  endtask
  task automatic t_abort();
    @(posedge clk);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    repeat (600) @(posedge clk);
    // by now the first program pulse is under way
    @(negedge clk);
    chk(ce_n, 1'b0);
    chk(vpp_en, 1'b1);
    chk(busy, 1'b1);
    do_reset();
    @(negedge clk);
    chk(vpp_en, 1'b0);
    chk(vcc_en, 1'b0);
    chk(busy, 1'b0);
    chk(ce_n, 1'b1);
    $display("test reset mid run done");
  endtask
  //////////////////////////////
  initial begin
    do_reset();
    t_prog(4'h1, 8'h5A, 8'hC3, 2);
    t_id();
    t_abort();
    t_prog(4'h2, 8'h3C, 8'h81, 4);
    stop_test();
  end
endmodule
`default_nettype wire
